/* File: logic/scd_map.svh */
// Strap positions, encodings, register offsets and timing for scd
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
`define SCD_STRAP_DEFAULT 32'hFFFFFFFF
`define SCD_RETRY_LO 6
`define SCD_RETRY_HI 7
`define SCD_TRUNK01_BIT 16
`define SCD_TRUNK67_BIT 17
`define SCD_BP_BIT 18
`define SCD_FC_LO 19
`define SCD_FC_HI 20
`define SCD_MASK_LO 21
`define SCD_MASK_HI 23
`define SCD_HASH_BIT 24
`define SCD_SWAP_BIT 25
`define SCD_AGING_BIT 26
`define SCD_CUT_BIT 27
`define SCD_BACKOFF_BIT 28
`define SCD_COLL_BIT 29
`define SCD_TEST_BIT 30
`define SCD_LATCH_BIT 31
`define SCD_RETRY_THREE 2'h3
`define SCD_RETRY_TWO 2'h2
`define SCD_RETRY_FOREVER 2'h1
`define SCD_RETRY_ONE 2'h0
`define SCD_LIMIT_THREE 2'h3
`define SCD_LIMIT_TWO 2'h2
`define SCD_LIMIT_ONE 2'h1
`define SCD_LIMIT_NONE 2'h0
`define SCD_FC_FORCE_OFF 2'h2
`define SCD_FC_FORCE_ON 2'h1
`define SCD_HASH_CRC 2'h0
`define SCD_HASH_DIRECT 2'h3
`define SCD_COLL_LATE 6'h20
`define SCD_COLL_EARLY 6'h02
`define SCD_FIXED_GROUPS 3'h7
`define SCD_OFFSET_BIT 1'h1
`define SCD_OFF_RAW 12'h000
`define SCD_OFF_CFG 12'h004
`define SCD_OFF_CTRL 12'h008
`define SCD_OFF_RETRY 12'h00C
`define SCD_CTRL_RESET 1'h0
`define SCD_LED_PERIOD_MS 50
`define SCD_CLK_NS 20
`define SCD_NS_PER_MS 1000000
`endif

/* File: logic/scd_pkg.sv */
// Types shared by the strap configuration decoder
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_HOLD0 = 2'b00,
        SCD_HOLD1 = 2'b01,
        SCD_HOLD2 = 2'b10,
        SCD_RUN = 2'b11
    } scd_phase_e;

    typedef struct packed {
        logic [1:0] retry_limit;
        logic trunk_01;
        logic trunk_67;
        logic hd_ignore_xonxoff;
        logic adv_fc_bit;
        logic partner_poll_en;
        logic rmii_fc_en;
        logic [5:0] lamp_group_output_mask;
        logic [1:0] lookup_hash_field;
        logic shared_pin_function_select;
        logic aging_en;
        logic early_forward_en;
        logic modified_retreat_mode_bit;
        logic retreat_offset_bit;
        logic [5:0] forced_collision_byte;
        logic factory_check_en;
        logic output_float;
    } scd_cfg_s;

    typedef struct packed {
        scd_phase_e phase;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] raw;
        scd_cfg_s cfg;
        logic led_run;
        logic [1:0] tries;
        logic discard;
        logic [21:0] led_cnt;
        logic led_burst;
        logic [31:0] prdata;
    } scd_state_s;
endpackage

/* File: logic/scd_strap_decoder.sv */
// Strap capture, decode and APB status for the switch configuration
//
// Operation
// - Retry strap 11 three tries, 10 two, 01 forever, 00 one try
// - A try is a sixteen-collision turn; used-up tries discard frame
// - Strap bits 15 to 8 are reserved and ignored
// - Bit 16 low trunks ports 0,1; bit 17 low trunks ports 6,7
// - Trunked ports: no auto-polling, forced full duplex 100M, flow on
// - Backpressure strap low: half-duplex transmit MACs ignore XON/XOFF
// - Flow strap 11 or 00: advertise bit 4.10 one, poll partner 5.10
// - Flow strap 10: advertise zero, no polling, port flow control off
// - Flow strap 01: advertise one, no polling, port flow control on
// - Mask bits gate lamp groups 0 to 2; groups 3 to 5 always on
// - Lamp bit sequence repeats every 50 ms
// - Hash strap high: CRC hashing, field 0; low: direct, field 3
// - Pin-swap strap high: shared pins carry prom; low: lamp signals
// - Aging strap high enables table aging, low disables it
// - Cut-through strap high store-and-forward, low cut-through
// - Backoff strap low: modified mode; high: mode 0, offset 1
// - Collision strap high forces collision at byte 32, low byte 2
// - Test strap high keeps test mode off; low enables it
// - Latch-up strap low floats output-only pads after reset
// - Unpulled straps read as one, selecting every default
`timescale 1ns/100ps
`include "scd_map.svh"

module scd_strap_decoder
    import scd_pkg::*;
#(
    parameter int unsigned LED_PERIOD_CYC =
        (`SCD_LED_PERIOD_MS * `SCD_NS_PER_MS) / `SCD_CLK_NS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] sram_data_strap_bus,
    input wire logic frame_start,
    input wire logic coll16_turn,
    output logic frame_discard,
    output scd_cfg_s cfg,
    output logic cfg_valid,
    output logic [7:0] port_autopoll_en,
    output logic [7:0] port_force_fd100,
    output logic [7:0] port_fc_value,
    output logic led_burst,
    input wire logic prom_serial_data,
    input wire logic prom_serial_clock,
    input wire logic lamp_serial_data,
    input wire logic lamp_serial_clock,
    output logic shared_pin_data,
    output logic shared_pin_clock,
    output logic output_pad_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic scd_cfg_s decode(input logic [31:0] s);
        scd_cfg_s c;
        logic [1:0] fc;
        c = '0;
        fc = s[`SCD_FC_HI:`SCD_FC_LO];
        unique case (s[`SCD_RETRY_HI:`SCD_RETRY_LO])
            `SCD_RETRY_THREE: c.retry_limit = `SCD_LIMIT_THREE;
            `SCD_RETRY_TWO: c.retry_limit = `SCD_LIMIT_TWO;
            `SCD_RETRY_FOREVER: c.retry_limit = `SCD_LIMIT_NONE;
            `SCD_RETRY_ONE: c.retry_limit = `SCD_LIMIT_ONE;
        endcase
        // Bits 15..8 are never looked at
        c.trunk_01 = !s[`SCD_TRUNK01_BIT];
        c.trunk_67 = !s[`SCD_TRUNK67_BIT];
        c.hd_ignore_xonxoff = !s[`SCD_BP_BIT];
        c.adv_fc_bit = (fc != `SCD_FC_FORCE_OFF);
        c.partner_poll_en = (fc != `SCD_FC_FORCE_OFF)
            && (fc != `SCD_FC_FORCE_ON);
        c.rmii_fc_en = (fc == `SCD_FC_FORCE_ON);
        c.lamp_group_output_mask =
            {`SCD_FIXED_GROUPS, s[`SCD_MASK_HI:`SCD_MASK_LO]};
        c.lookup_hash_field = s[`SCD_HASH_BIT] ? `SCD_HASH_CRC
            : `SCD_HASH_DIRECT;
        c.shared_pin_function_select = s[`SCD_SWAP_BIT];
        c.aging_en = s[`SCD_AGING_BIT];
        c.early_forward_en = !s[`SCD_CUT_BIT];
        c.modified_retreat_mode_bit = !s[`SCD_BACKOFF_BIT];
        c.retreat_offset_bit = `SCD_OFFSET_BIT;
        c.forced_collision_byte = s[`SCD_COLL_BIT] ? `SCD_COLL_LATE
            : `SCD_COLL_EARLY;
        c.factory_check_en = !s[`SCD_TEST_BIT];
        c.output_float = !s[`SCD_LATCH_BIT];
        return c;
    endfunction

    // Before capture every setting shows its unpulled default
    localparam scd_cfg_s CFG_DEFAULT = decode(`SCD_STRAP_DEFAULT);
    localparam logic [21:0] LED_LAST = 22'(LED_PERIOD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // State

    scd_state_s st;
    scd_state_s next_st;
    logic setup;
    logic access;
    logic mapped;
    logic [1:0] tries_inc;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == `SCD_OFF_RAW) || (paddr == `SCD_OFF_CFG)
        || (paddr == `SCD_OFF_CTRL) || (paddr == `SCD_OFF_RETRY);
    assign tries_inc = st.tries + 2'h1;

    always_comb
    begin
        next_st = st;
        // Pins cross into pclk through two stages before use
        next_st.sync1 = sram_data_strap_bus;
        next_st.sync2 = st.sync1;
        unique case (st.phase)
            SCD_HOLD0: next_st.phase = SCD_HOLD1;
            SCD_HOLD1: next_st.phase = SCD_HOLD2;
            SCD_HOLD2:
            begin
                // Second stage now holds levels seen after release
                next_st.phase = SCD_RUN;
                next_st.raw = st.sync2;
                next_st.cfg = decode(st.sync2);
            end
            SCD_RUN: next_st.phase = SCD_RUN;
        endcase

        // Excess-collision turn counting
        next_st.discard = 1'b0;
        if (frame_start)
        begin
            next_st.tries = 2'h0;
        end
        else if (coll16_turn)
        begin
            if (st.cfg.retry_limit != `SCD_LIMIT_NONE
                && tries_inc == st.cfg.retry_limit)
            begin
                next_st.discard = 1'b1;
                next_st.tries = 2'h0;
            end
            else if (st.cfg.retry_limit != `SCD_LIMIT_NONE)
            begin
                next_st.tries = tries_inc;
            end
        end

        // Lamp burst pacing; held idle until software starts it
        next_st.led_burst = 1'b0;
        if (!st.led_run || st.phase != SCD_RUN)
        begin
            next_st.led_cnt = '0;
        end
        else if (st.led_cnt == LED_LAST)
        begin
            next_st.led_cnt = '0;
            next_st.led_burst = 1'b1;
        end
        else
        begin
            next_st.led_cnt = st.led_cnt + 22'h1;
        end

        // APB: read data latched in setup so access completes at once
        if (setup && !pwrite)
        begin
            unique case (paddr)
                `SCD_OFF_RAW: next_st.prdata = st.raw;
                `SCD_OFF_CFG: next_st.prdata = 32'(st.cfg);
                `SCD_OFF_CTRL: next_st.prdata = 32'(st.led_run);
                `SCD_OFF_RETRY:
                    next_st.prdata = 32'({st.phase == SCD_RUN, st.tries});
                default: next_st.prdata = 32'h00000000;
            endcase
        end
        if (access && pwrite && paddr == `SCD_OFF_CTRL)
        begin
            next_st.led_run = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '{phase: SCD_HOLD0, sync1: `SCD_STRAP_DEFAULT,
                    sync2: `SCD_STRAP_DEFAULT, raw: `SCD_STRAP_DEFAULT,
                    cfg: CFG_DEFAULT, led_run: `SCD_CTRL_RESET,
                    tries: 2'h0, discard: 1'b0, led_cnt: 22'h000000,
                    led_burst: 1'b0, prdata: 32'h00000000};
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic [7:0] trunk_mask;
    assign trunk_mask = {st.cfg.trunk_67, st.cfg.trunk_67, 4'h0,
        st.cfg.trunk_01, st.cfg.trunk_01};

    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign cfg = st.cfg;
    assign cfg_valid = (st.phase == SCD_RUN);
    assign frame_discard = st.discard;
    assign led_burst = st.led_burst;
    // Trunk links are wired on board, so polling them is meaningless
    assign port_autopoll_en = {8{st.cfg.partner_poll_en}}
        & ~trunk_mask;
    assign port_force_fd100 = trunk_mask;
    assign port_fc_value = trunk_mask
        | {8{st.cfg.rmii_fc_en}};
    assign shared_pin_data = st.cfg.shared_pin_function_select
        ? prom_serial_data : lamp_serial_data;
    assign shared_pin_clock = st.cfg.shared_pin_function_select
        ? prom_serial_clock : lamp_serial_clock;
    // Pads stay driven while straps settle; float only once captured
    assign output_pad_enable = !(st.cfg.output_float
        && st.phase == SCD_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_retry_discard: assert property (@(posedge pclk) disable iff (!presetn)
        (!frame_start && coll16_turn && st.cfg.retry_limit != 2'h0
         && tries_inc == st.cfg.retry_limit) |=> frame_discard)
        else $error("discard missing after last try");

    a_retry_forever: assert property (@(posedge pclk) disable iff (!presetn)
        (st.cfg.retry_limit == 2'h0) |=> !frame_discard)
        else $error("discard with unlimited retries");

    a_strap_capture: assert property (@(posedge pclk) disable iff (!presetn)
        (st.phase == SCD_HOLD2) |=> (cfg_valid
         && st.raw == $past(st.sync2)))
        else $error("straps not captured after release");

    a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_valid) |-> ($stable(st.raw) && $stable(cfg)))
        else $error("captured settings changed");

    a_flow_forced: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid && st.raw[20:19] == 2'b10) |-> (!cfg.adv_fc_bit
         && port_fc_value == trunk_mask && port_autopoll_en == 8'h00))
        else $error("forced-off flow policy wrong");

    a_flow_poll: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid && st.raw[20] == st.raw[19]) |-> (cfg.adv_fc_bit
         && port_autopoll_en == ~trunk_mask))
        else $error("polled flow policy wrong");

    a_trunk_force: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid && !st.raw[16]) |-> (port_autopoll_en[1:0] == 2'b00
         && port_fc_value[1:0] == 2'b11
         && port_force_fd100[1:0] == 2'b11))
        else $error("trunk ports not forced");

    a_hash_field: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> (cfg.lookup_hash_field
         == (st.raw[24] ? 2'h0 : 2'h3)))
        else $error("hash field mismatch");

    a_led_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        led_burst |=> !led_burst [*8])
        else $error("lamp bursts too close");

    a_pad_float: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_valid && !st.raw[31]) |-> !output_pad_enable)
        else $error("pads driven in latch-up mode");

    a_default_cfg: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_valid |-> (cfg.retry_limit == 2'h3 && !cfg.trunk_01
         && cfg.aging_en && !cfg.early_forward_en
         && cfg.forced_collision_byte == 6'h20))
        else $error("pre-capture settings not default");

    a_lamp_mask: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.lamp_group_output_mask[5:3] == 3'h7)
        else $error("fixed lamp groups masked");

endmodule

/* File: dv/scd_strap_board.sv */
// Board strap resistors on the SRAM data lines
`timescale 1ns/100ps

module scd_strap_board
(
    input wire logic [31:0] pull_low,
    output logic [31:0] sram_data_strap_bus
);
    // Unfitted straps sit at the pull-up level; a fitted pull-down wins
    assign sram_data_strap_bus = ~pull_low;
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the strap configuration decoder
`timescale 1ns/100ps

module tb
    import scd_pkg::*;
;
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); end end

logic pclk, presetn, psel, penable, pwrite, frame_start, coll16_turn;
logic pready, pslverr, frame_discard, cfg_valid, led_burst, er;
logic shared_pin_data, shared_pin_clock, output_pad_enable;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, strap_bus, pull_low, rd, s;
logic [7:0] port_autopoll_en, port_force_fd100, port_fc_value, tm;
scd_cfg_s cfg, e;
int err_count, checks, cyc, n;
logic [31:0] pats [4] = '{32'hFFFFFFFF, 32'h00000080, 32'h55155555,
    32'hAA8AAA2A};

scd_strap_board board (.pull_low(pull_low), .sram_data_strap_bus(strap_bus));

// Short lamp period keeps the run brief
scd_strap_decoder #(.LED_PERIOD_CYC(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sram_data_strap_bus(strap_bus),
    .frame_start(frame_start), .coll16_turn(coll16_turn),
    .frame_discard(frame_discard), .cfg(cfg), .cfg_valid(cfg_valid),
    .port_autopoll_en(port_autopoll_en), .port_force_fd100(port_force_fd100),
    .port_fc_value(port_fc_value), .led_burst(led_burst),
    .prom_serial_data(1'b1), .prom_serial_clock(1'b0),
    .lamp_serial_data(1'b0), .lamp_serial_clock(1'b1),
    .shared_pin_data(shared_pin_data), .shared_pin_clock(shared_pin_clock),
    .output_pad_enable(output_pad_enable));

////////////////////////////////////////////////////////////////////////////
initial
begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
end

always @(posedge pclk)
begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
        err_count++;
        tally_and_finish();
    end
end

////////////////////////////////////////////////////////////////////////////
task tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

// Entered just after a rising edge; one idle cycle follows each transfer
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a stalled access
    while (pready !== 1'b1)
    begin
        @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask

task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    `CHK(rd, x)
endtask

// Polled ports leave the flow enable open, so it is not compared then
task cfg_chk(input scd_cfg_s c);
    if (e.partner_poll_en)
        c.rmii_fc_en = e.rmii_fc_en;
    `CHK(c, e)
endtask

task boot(input logic [31:0] v);
    s = v;
    pull_low <= ~v;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 20)
    begin
        n++;
        @(posedge pclk);
    end
    @(posedge pclk);
endtask

task retry_run(input int t, input logic last);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    for (int i = 0; i < t; i++)
    begin
        coll16_turn <= 1'b1;
        @(posedge pclk);
        coll16_turn <= 1'b0;
        #1;
        `CHK(frame_discard, last && i == t - 1)
        @(posedge pclk);
    end
endtask

task wait_burst();
    n = 0;
    do
    begin
        @(posedge pclk);
        #1;
        n++;
    end while (led_burst !== 1'b1 && n < 100);
endtask

function automatic scd_cfg_s exp_cfg(input logic [31:0] v);
    scd_cfg_s c;
    c.retry_limit = v[7:6] == 2'h1 ? 2'h0 : v[7:6] == 2'h0 ? 2'h1 : v[7:6];
    c.trunk_01 = !v[16];
    c.trunk_67 = !v[17];
    c.hd_ignore_xonxoff = !v[18];
    c.adv_fc_bit = v[20:19] != 2'h2;
    c.partner_poll_en = v[20] == v[19];
    c.rmii_fc_en = v[20:19] == 2'h1;
    c.lamp_group_output_mask = {3'h7, v[23:21]};
    c.lookup_hash_field = v[24] ? 2'h0 : 2'h3;
    c.shared_pin_function_select = v[25];
    c.aging_en = v[26];
    c.early_forward_en = !v[27];
    c.modified_retreat_mode_bit = !v[28];
    c.retreat_offset_bit = 1'b1;
    c.forced_collision_byte = v[29] ? 6'h20 : 6'h02;
    c.factory_check_en = !v[30];
    c.output_float = !v[31];
    return c;
endfunction

////////////////////////////////////////////////////////////////////////////
initial
begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    frame_start = 1'b0;
    coll16_turn = 1'b0;
    pull_low = 32'h00000000;
    err_count = 0;
    checks = 0;
    foreach (pats[k])
    begin
        boot(pats[k]);
        e = exp_cfg(s);
        cfg_chk(cfg);
        cfg_chk(cfg);
        `CHK(cfg_valid, 1'b1)
        tm = {{2{e.trunk_67}}, 4'h0, {2{e.trunk_01}}};
        `CHK(port_force_fd100, tm)
        `CHK(port_autopoll_en, e.partner_poll_en ? ~tm : 8'h00)
        `CHK(port_fc_value & tm, tm)
        if (!e.partner_poll_en)
            `CHK(port_fc_value, tm | {8{e.rmii_fc_en}})
        `CHK(shared_pin_data, s[25])
        `CHK(shared_pin_clock, !s[25])
        `CHK(output_pad_enable, s[31])
        rdchk(12'h000, s);
        apb(1'b0, 12'h004, 32'h00000000);
        cfg_chk(scd_cfg_s'(rd[28:0]));
        rdchk(12'h008, 32'h00000000);
        apb(1'b1, 12'h000, 32'h00000000);
        rdchk(12'h000, s);
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        if (e.retry_limit == 2'h0)
            retry_run(5, 1'b0);
        else
        begin
            retry_run(e.retry_limit - 1, 1'b0);
            // Tries used so far, with the captured flag in bit 2
            rdchk(12'h00C, {30'h1, e.retry_limit - 2'h1});
            retry_run(e.retry_limit, 1'b1);
        end
        // Pins moving after capture must not reach the settings
        pull_low <= ~pats[(k + 1) % 4];
        repeat (5) @(posedge pclk);
        cfg_chk(cfg);
        rdchk(12'h000, s);
        $display("strap pattern %0d done", k);
    end
    apb(1'b1, 12'h008, 32'h00000001);
    rdchk(12'h008, 32'h00000001);
    wait_burst();
    wait_burst();
    `CHK(n, 16)
    $display("lamp timer test done");
    tally_and_finish();
end
endmodule
